/* logic/down_timer_consts.svh */
// Constants of the dual down timer: register indices, field positions,
// reset values and prescaler ratio limits. Definitions only.
`ifndef DOWN_TIMER_CONSTS_SVH
`define DOWN_TIMER_CONSTS_SVH

// Register indices; byte address is four times the index
`define IDX_TIMER_MODE_CONFIG 16'hFFC0
`define IDX_CLOCK_SOURCE_AND_OUTPUT_CTRL 16'hFFC1
`define IDX_TIMER_ZERO_CONTROL 16'hFFC2
`define IDX_TIMER_ONE_CONTROL 16'hFFC3
`define IDX_TIMER_ZERO_RELOAD_LOW 16'hFFC4
`define IDX_TIMER_ZERO_RELOAD_HIGH 16'hFFC5
`define IDX_TIMER_ONE_RELOAD_LOW 16'hFFC6
`define IDX_TIMER_ONE_RELOAD_HIGH 16'hFFC7
`define IDX_TIMER_ZERO_COUNT_LOW 16'hFFC8
`define IDX_TIMER_ZERO_COUNT_HIGH 16'hFFC9
`define IDX_TIMER_ONE_COUNT_LOW 16'hFFCA
`define IDX_TIMER_ONE_COUNT_HIGH 16'hFFCB
`define IDX_TIMER_INTERRUPT_ENABLE 16'hFFE2
`define IDX_TIMER_INTERRUPT_FLAGS 16'hFFF2

// Mode register fields
`define BIT_EDGE_POLARITY_SELECT 0
`define BIT_NOISE_FILTER_SELECT 1
`define BIT_EVENT_COUNT_SELECT 2
`define BIT_CHAINED_WIDTH_SELECT 3
// Clock source and output register fields
`define BIT_PRESCALER_ZERO_SOURCE_SEL 0
`define BIT_PRESCALER_ONE_SOURCE_SEL 1
`define BIT_PULSE_OUTPUT_ENABLE 2
`define BIT_PULSE_CHANNEL_SELECT 3
// Timer control register fields
`define BIT_RUN 0
`define BIT_RELOAD_STROBE 1
`define LSB_RATIO 2

// Reset values
`define RST_NIBBLE 4'h0
`define RST_BYTE 8'h00
`define RST_RATIO 2'h0

// Prescaler terminal counts for ratios 1, 4, 32, 256
`define PRE_LIMIT_DIV1 8'h00
`define PRE_LIMIT_DIV4 8'h03
`define PRE_LIMIT_DIV32 8'h1F
`define PRE_LIMIT_DIV256 8'hFF

`endif

/* logic/down_timer_pkg.sv */
// Types of the dual down timer: Wishbone carriers and filter states.
// Assumes a 32-bit classic Wishbone bus with 18-bit byte addresses.
package down_timer_pkg;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [17:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
    } wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } wb_rsp_t;

    typedef enum logic [2:0] {
        FLT_STABLE = 3'b001,
        FLT_WAIT_FIRST = 3'b010,
        FLT_WAIT_SECOND = 3'b100
    } filter_state_t;

endpackage

/* logic/dual_down_timer.sv */
// Two 8-bit reloadable down timers, chainable to 16 bits, with prescalers,
// event counting, noise rejection, pulse output and serial clock output.
// Assumes oscillator, event and 2048 Hz reference inputs are synchronous
// to clk_sys_in and much slower than it.
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
`include "down_timer_consts.svh"

module dual_down_timer (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Wishbone slave
    input wire down_timer_pkg::wb_req_t wb_req_in,
    output down_timer_pkg::wb_rsp_t wb_rsp_out,
    // Clock sources and event input
    input wire logic low_freq_oscillator_in,
    input wire logic high_freq_oscillator_in,
    input wire logic ref_2048hz_in,
    input wire logic event_input_pin_in,
    // Outputs to serial interface, port and interrupt controller
    output logic serial_clock_out,
    output logic underflow_pulse_output_out,
    output logic timer_zero_irq_out,
    output logic timer_one_irq_out
);
    import down_timer_pkg::*;

    // Software registers
    logic [3:0] mode_r;
    logic [3:0] src_ctrl_r;
    logic [1:0] ratio_r [2];
    logic [1:0] run_r;
    logic [7:0] reload_r [2];
    logic [7:0] count_r [2];
    logic [3:0] hold_r [2];
    logic [1:0] irq_enable_r;
    logic [1:0] irq_flag_r;

    // Internal state
    logic [7:0] pre_r [2];
    logic lf_prev_r;
    logic hf_prev_r;
    logic ref_prev_r;
    logic ev_prev_r;
    logic filt_level_r;
    logic src_level_prev_r;
    filter_state_t flt_state_r;
    logic serial_clock_r;
    logic pulse_toggle_r;
    logic pulse_out_r;
    logic [1:0] irq_r;
    wb_rsp_t rsp_r;

    // Decoded controls
    logic chained;
    logic event_mode;
    logic filter_sel;
    logic rising_sel;
    assign chained = mode_r[`BIT_CHAINED_WIDTH_SELECT];
    assign event_mode = mode_r[`BIT_EVENT_COUNT_SELECT];
    assign filter_sel = mode_r[`BIT_NOISE_FILTER_SELECT];
    assign rising_sel = mode_r[`BIT_EDGE_POLARITY_SELECT];

    // Bus decode; access is taken on the edge that raises ack
    logic bus_take;
    logic bus_wr;
    logic bus_rd;
    logic [15:0] idx;
    logic [3:0] wd;
    assign bus_take = wb_req_in.cyc && wb_req_in.stb && !rsp_r.ack;
    assign bus_wr = bus_take && wb_req_in.we && wb_req_in.sel[0];
    assign bus_rd = bus_take && !wb_req_in.we;
    assign idx = wb_req_in.adr[17:2];
    assign wd = wb_req_in.dat[3:0];

    // Prescaler terminal count for a ratio code
    function automatic logic [7:0] pre_limit(input logic [1:0] code);
        unique case (code)
            2'h0: pre_limit = `PRE_LIMIT_DIV1;
            2'h1: pre_limit = `PRE_LIMIT_DIV4;
            2'h2: pre_limit = `PRE_LIMIT_DIV32;
            2'h3: pre_limit = `PRE_LIMIT_DIV256;
        endcase
    endfunction

    // Source edges
    logic lf_edge;
    logic hf_edge;
    logic ref_fall;
    logic [1:0] src_edge;
    logic [1:0] pre_tick;
    assign lf_edge = low_freq_oscillator_in && !lf_prev_r;
    assign hf_edge = high_freq_oscillator_in && !hf_prev_r;
    assign ref_fall = !ref_2048hz_in && ref_prev_r;
    assign src_edge[0] = src_ctrl_r[`BIT_PRESCALER_ZERO_SOURCE_SEL] ? hf_edge : lf_edge;
    assign src_edge[1] = src_ctrl_r[`BIT_PRESCALER_ONE_SOURCE_SEL] ? hf_edge : lf_edge;
    assign pre_tick[0] = src_edge[0] && (pre_r[0] == pre_limit(ratio_r[0]));
    assign pre_tick[1] = src_edge[1] && (pre_r[1] == pre_limit(ratio_r[1]));

    // Event edge from the raw or filtered level
    logic src_level;
    logic ev_edge;
    assign src_level = filter_sel ? filt_level_r : ev_prev_r;
    assign ev_edge = rising_sel ? (src_level && !src_level_prev_r)
                                : (!src_level && src_level_prev_r);

    // Count steps and underflows
    logic [1:0] step;
    logic [1:0] uf;
    logic pulse_src;
    assign step[0] = run_r[0] && (event_mode ? ev_edge : pre_tick[0]);
    assign step[1] = chained ? (step[0] && count_r[0] == `RST_BYTE)
                             : (run_r[1] && pre_tick[1]);
    assign uf[0] = step[0] && count_r[0] == `RST_BYTE;
    assign uf[1] = step[1] && count_r[1] == `RST_BYTE;
    assign pulse_src = (chained || src_ctrl_r[`BIT_PULSE_CHANNEL_SELECT]) ? uf[1] : uf[0];

    // Edge history of sampled inputs
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            lf_prev_r <= 1'b0;
            hf_prev_r <= 1'b0;
            ref_prev_r <= 1'b0;
            ev_prev_r <= 1'b0;
            src_level_prev_r <= 1'b0;
        end
        else
        begin
            lf_prev_r <= low_freq_oscillator_in;
            hf_prev_r <= high_freq_oscillator_in;
            ref_prev_r <= ref_2048hz_in;
            ev_prev_r <= event_input_pin_in;
            src_level_prev_r <= src_level;
        end
    end

    // Noise rejecter: a changed level is accepted at the second reference fall
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            flt_state_r <= FLT_STABLE;
            filt_level_r <= 1'b0;
        end
        else if (ev_prev_r == filt_level_r)
        begin
            flt_state_r <= FLT_STABLE;
        end
        else
        begin
            unique case (flt_state_r)
                FLT_STABLE: flt_state_r <= ref_fall ? FLT_WAIT_SECOND : FLT_WAIT_FIRST;
                FLT_WAIT_FIRST:
                begin
                    if (ref_fall)
                    begin
                        flt_state_r <= FLT_WAIT_SECOND;
                    end
                end
                FLT_WAIT_SECOND:
                begin
                    if (ref_fall)
                    begin
                        filt_level_r <= ev_prev_r;
                        flt_state_r <= FLT_STABLE;
                    end
                end
                default: flt_state_r <= FLT_STABLE;
            endcase
        end
    end

    // Prescalers, cleared while stopped
    always_ff @(posedge clk_sys_in)
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (!rst_n_in || !run_r[i] || pre_tick[i])
            begin
                pre_r[i] <= `RST_BYTE;
            end
            else if (src_edge[i])
            begin
                pre_r[i] <= pre_r[i] + 8'h01;
            end
        end
    end

    // Configuration registers
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            mode_r <= `RST_NIBBLE;
            src_ctrl_r <= `RST_NIBBLE;
            ratio_r[0] <= `RST_RATIO;
            ratio_r[1] <= `RST_RATIO;
            run_r <= 2'h0;
            irq_enable_r <= 2'h0;
        end
        else if (bus_wr)
        begin
            unique case (idx)
                `IDX_TIMER_MODE_CONFIG: mode_r <= wd;
                `IDX_CLOCK_SOURCE_AND_OUTPUT_CTRL: src_ctrl_r <= wd;
                `IDX_TIMER_ZERO_CONTROL:
                begin
                    ratio_r[0] <= wd[`LSB_RATIO +: 2];
                    run_r[0] <= wd[`BIT_RUN];
                end
                `IDX_TIMER_ONE_CONTROL:
                begin
                    ratio_r[1] <= wd[`LSB_RATIO +: 2];
                    run_r[1] <= wd[`BIT_RUN];
                end
                `IDX_TIMER_INTERRUPT_ENABLE: irq_enable_r <= wd[1:0];
                default: ;
            endcase
        end
    end

    // Reload values
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            reload_r[0] <= `RST_BYTE;
            reload_r[1] <= `RST_BYTE;
        end
        else if (bus_wr)
        begin
            unique case (idx)
                `IDX_TIMER_ZERO_RELOAD_LOW: reload_r[0][3:0] <= wd;
                `IDX_TIMER_ZERO_RELOAD_HIGH: reload_r[0][7:4] <= wd;
                `IDX_TIMER_ONE_RELOAD_LOW: reload_r[1][3:0] <= wd;
                `IDX_TIMER_ONE_RELOAD_HIGH: reload_r[1][7:4] <= wd;
                default: ;
            endcase
        end
    end

    // Down counters; a preset strobe wins over a count step
    logic [1:0] preset;
    assign preset[0] = bus_wr && idx == `IDX_TIMER_ZERO_CONTROL && wd[`BIT_RELOAD_STROBE];
    assign preset[1] = bus_wr && idx == `IDX_TIMER_ONE_CONTROL && wd[`BIT_RELOAD_STROBE];
    always_ff @(posedge clk_sys_in)
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (!rst_n_in)
            begin
                count_r[i] <= `RST_BYTE;
            end
            else if (preset[i] || uf[i])
            begin
                count_r[i] <= reload_r[i];
            end
            else if (step[i])
            begin
                count_r[i] <= count_r[i] - 8'h01;
            end
        end
    end

    // Interrupt flags: set wins over a clearing write
    logic [1:0] flag_set;
    logic [1:0] flag_clr;
    assign flag_set[0] = uf[0] && !chained;
    assign flag_set[1] = uf[1];
    assign flag_clr = (bus_wr && idx == `IDX_TIMER_INTERRUPT_FLAGS) ? wd[1:0] : 2'h0;
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            irq_flag_r <= 2'h0;
            irq_r <= 2'h0;
        end
        else
        begin
            irq_flag_r <= (irq_flag_r & ~flag_clr) | flag_set;
            irq_r <= irq_flag_r & irq_enable_r;
        end
    end

    // Serial clock and pulse output dividers
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            serial_clock_r <= 1'b0;
            pulse_toggle_r <= 1'b0;
            pulse_out_r <= 1'b1;
        end
        else
        begin
            serial_clock_r <= serial_clock_r ^ uf[1];
            pulse_toggle_r <= pulse_toggle_r ^ pulse_src;
            pulse_out_r <= src_ctrl_r[`BIT_PULSE_OUTPUT_ENABLE]
                           ? (pulse_toggle_r ^ pulse_src) : 1'b1;
        end
    end

    // Read data and high nibble hold
    logic [3:0] rd_nib;
    always_comb
    begin
        rd_nib = `RST_NIBBLE;
        unique case (idx)
            `IDX_TIMER_MODE_CONFIG: rd_nib = mode_r;
            `IDX_CLOCK_SOURCE_AND_OUTPUT_CTRL: rd_nib = src_ctrl_r;
            `IDX_TIMER_ZERO_CONTROL: rd_nib = {ratio_r[0], 1'b0, run_r[0]};
            `IDX_TIMER_ONE_CONTROL: rd_nib = {ratio_r[1], 1'b0, run_r[1]};
            `IDX_TIMER_ZERO_RELOAD_LOW: rd_nib = reload_r[0][3:0];
            `IDX_TIMER_ZERO_RELOAD_HIGH: rd_nib = reload_r[0][7:4];
            `IDX_TIMER_ONE_RELOAD_LOW: rd_nib = reload_r[1][3:0];
            `IDX_TIMER_ONE_RELOAD_HIGH: rd_nib = reload_r[1][7:4];
            `IDX_TIMER_ZERO_COUNT_LOW: rd_nib = count_r[0][3:0];
            `IDX_TIMER_ZERO_COUNT_HIGH: rd_nib = hold_r[0];
            `IDX_TIMER_ONE_COUNT_LOW: rd_nib = count_r[1][3:0];
            `IDX_TIMER_ONE_COUNT_HIGH: rd_nib = hold_r[1];
            `IDX_TIMER_INTERRUPT_ENABLE: rd_nib = {2'h0, irq_enable_r};
            `IDX_TIMER_INTERRUPT_FLAGS: rd_nib = {2'h0, irq_flag_r};
            default: rd_nib = `RST_NIBBLE;
        endcase
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            hold_r[0] <= `RST_NIBBLE;
            hold_r[1] <= `RST_NIBBLE;
        end
        else if (bus_rd && idx == `IDX_TIMER_ZERO_COUNT_LOW)
        begin
            hold_r[0] <= count_r[0][7:4];
        end
        else if (bus_rd && idx == `IDX_TIMER_ONE_COUNT_LOW)
        begin
            hold_r[1] <= count_r[1][7:4];
        end
    end

    // Wishbone answer: one wait state, ack for one cycle
    always_ff @(posedge clk_sys_in)
    begin
        if (!rst_n_in)
        begin
            rsp_r <= '0;
        end
        else
        begin
            rsp_r.ack <= bus_take;
            rsp_r.dat <= bus_rd ? {28'h0000000, rd_nib} : 32'h00000000;
        end
    end

    assign wb_rsp_out = rsp_r;
    assign serial_clock_out = serial_clock_r;
    assign underflow_pulse_output_out = pulse_out_r;
    assign timer_zero_irq_out = irq_r[0];
    assign timer_one_irq_out = irq_r[1];

    // Checks
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rst_n_in);

    sequence s_zero_step(int i);
        step[i] && count_r[i] == 8'h00 && !preset[i];
    endsequence

    sequence s_bus_clear(int b);
        bus_wr && idx == `IDX_TIMER_INTERRUPT_FLAGS && wd[b];
    endsequence

    a_serial_clk_toggle: assert property (uf[1] |=> serial_clock_out != $past(serial_clock_out))
        else $error("serial clock did not toggle on underflow");
    a_serial_clk_hold: assert property (!uf[1] |=> $stable(serial_clock_out))
        else $error("serial clock moved without underflow");
    a_reload_on_uf: assert property (s_zero_step(0) |=> count_r[0] == $past(reload_r[0]))
        else $error("timer 0 did not reload on underflow");
    a_flag_set_wins: assert property (s_bus_clear(1) ##0 uf[1] |=> irq_flag_r[1])
        else $error("timer 1 flag lost to a clear");
    a_flag_clears: assert property (s_bus_clear(0) ##0 !flag_set[0] |=> !irq_flag_r[0])
        else $error("timer 0 flag not cleared");
    a_stop_holds: assert property (!run_r[0] && !preset[0] |=> $stable(count_r[0]))
        else $error("timer 0 counted while stopped");
    a_preset_load: assert property (preset[1] |=> count_r[1] == $past(reload_r[1]))
        else $error("preset did not load timer 1");
    a_irq_gate: assert property (irq_flag_r[0] && irq_enable_r[0] |=> timer_zero_irq_out)
        else $error("enabled flag did not raise interrupt");
    a_chain_no_t0: assert property (chained && uf[0] && !irq_flag_r[0] |=> !irq_flag_r[0])
        else $error("timer 0 flag set in chained mode");
    a_pulse_off_high: assert property (!src_ctrl_r[`BIT_PULSE_OUTPUT_ENABLE]
                                       |=> underflow_pulse_output_out)
        else $error("disabled pulse output not high");
    a_ack_one: assert property (rsp_r.ack |=> !rsp_r.ack)
        else $error("ack held for more than one cycle");

endmodule
`default_nettype wire

/* verif/event_source_model.sv */
// Far side model: external event source and serial clock consumer.
// Assumes one pulse request at a time, synchronous to the system clock.
`timescale 1ns/1ns
`default_nettype none
module event_source_model (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_n_in,
    // Pulse request and serial clock
    input wire logic go_in,
    input wire logic [7:0] hold_in,
    input wire logic serial_clock_in,
    // Event line, activity and serial clock change count
    output logic event_pin_out,
    output logic busy_out,
    output logic [7:0] sclk_edges_out
);
    logic [8:0] left_r;
    logic sclk_r;
    assign busy_out = (left_r != 9'h000);
    // Idles high; a request holds low for hold_in+1 cycles, then high for hold_in cycles
    always_ff @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            left_r <= 9'h000;
            event_pin_out <= 1'b1;
        end
        else if (busy_out)
        begin
            left_r <= left_r - 9'h001;
            event_pin_out <= (left_r <= {1'b0, hold_in});
        end
        else if (go_in)
        begin
            left_r <= {hold_in, 1'b0};
            event_pin_out <= 1'b0;
        end
    end
    always_ff @(posedge clk_in)
    begin
        sclk_r <= serial_clock_in;
        if (!rst_n_in)
            sclk_edges_out <= 8'h00;
        else if (sclk_r != serial_clock_in)
            sclk_edges_out <= sclk_edges_out + 8'h01;
    end
endmodule
`default_nettype wire

/* verif/dual_down_timer_tb.sv */
// Self-checking bench for the dual down timer.
// Assumes a one-cycle bus answer and oscillators driven as level ticks.
`timescale 1ns/1ns
`default_nettype none
`include "down_timer_consts.svh"
module dual_down_timer_tb;
    import down_timer_pkg::*;
    logic clk_sys, rst_n, low_osc, high_osc, ref_clk, ev_pin, ev_go, ev_busy;
    logic sclk, pulse, pulse_q, irq0, irq1;
    logic [7:0] ev_hold, sclk_edges, r0, r1;
    logic [3:0] rc = 4'h0;
    wb_req_t req;
    wb_rsp_t rsp;
    integer seed;
    int n_errors, compares, pt, base, pb, i;
    // Prescaler division for a ratio code: 1, 4, 32, 256
    function automatic int div_of(input logic [1:0] code);
        return (code == 2'h0) ? 1 : (4 << (3 * (int'(code) - 1)));
    endfunction
    dual_down_timer u_dual_down_timer (
        .clk_sys_in(clk_sys), .rst_n_in(rst_n), .wb_req_in(req), .wb_rsp_out(rsp),
        .low_freq_oscillator_in(low_osc), .high_freq_oscillator_in(high_osc),
        .ref_2048hz_in(ref_clk), .event_input_pin_in(ev_pin), .serial_clock_out(sclk),
        .underflow_pulse_output_out(pulse), .timer_zero_irq_out(irq0),
        .timer_one_irq_out(irq1));
    event_source_model u_event_source_model (
        .clk_in(clk_sys), .rst_n_in(rst_n), .go_in(ev_go), .hold_in(ev_hold),
        .serial_clock_in(sclk), .event_pin_out(ev_pin), .busy_out(ev_busy),
        .sclk_edges_out(sclk_edges));
    assign ref_clk = rc[3];
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    // Reference period of 16 cycles; counts pulse output changes
    always @(posedge clk_sys)
    begin
        rc <= rc + 4'h1;
        pulse_q <= pulse;
        if (pulse_q !== pulse) pt <= pt + 1;
    end
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] a, input logic [3:0] d,
                       output logic [3:0] q);
        int n;
        n = 0;
        req <= {2'b11, w, a, 2'b00, 28'h0, d, 4'hF};
        @(posedge clk_sys);
        while (rsp.ack !== 1'b1 && n < 50)
        begin
            n++;
            @(posedge clk_sys);
        end
        q = rsp.dat[3:0];
        req <= '0;
        @(posedge clk_sys);
        cmp(8'(n / 50), 8'h00);
    endtask
    task automatic wr(input logic [15:0] a, input logic [3:0] d);
        logic [3:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic chk(input logic [15:0] a, input logic [3:0] e);
        logic [3:0] q;
        bus(1'b0, a, 4'h0, q);
        cmp({4'h0, q}, {4'h0, e});
    endtask
    task automatic rdcnt(input logic t, input logic [7:0] e);
        chk(`IDX_TIMER_ZERO_COUNT_LOW + {14'h0, t, 1'b0}, e[3:0]);
        chk(`IDX_TIMER_ZERO_COUNT_HIGH + {14'h0, t, 1'b0}, e[7:4]);
    endtask
    // Loads a reload value, presets it and checks the counter
    task automatic setrl(input logic t, input logic [7:0] v);
        logic [15:0] a;
        a = `IDX_TIMER_ZERO_RELOAD_LOW + {14'h0, t, 1'b0};
        wr(a, v[3:0]);
        wr(a + 16'h1, v[7:4]);
        chk(a, v[3:0]);
        chk(a + 16'h1, v[7:4]);
        wr(`IDX_TIMER_ZERO_CONTROL + {15'h0, t}, 4'h2);
        chk(`IDX_TIMER_ZERO_CONTROL + {15'h0, t}, 4'h0);
        rdcnt(t, v);
    endtask
    task automatic tick(input logic hi, input int n);
        repeat (n)
        begin
            {high_osc, low_osc} <= {hi, !hi};
            repeat (2) @(posedge clk_sys);
            {high_osc, low_osc} <= 2'b00;
            repeat (2) @(posedge clk_sys);
        end
    endtask
    // One event pulse; count checked mid-pulse (long pulses) and after it
    task automatic ev(input logic [7:0] h, input logic [7:0] mid, input logic [7:0] fin);
        int n;
        n = 0;
        ev_hold <= h;
        ev_go <= 1'b1;
        @(posedge clk_sys);
        ev_go <= 1'b0;
        repeat (16) @(posedge clk_sys);
        if (h > 8'h10) rdcnt(1'b0, mid);
        while (ev_busy === 1'b1 && n < 400)
        begin
            n++;
            @(posedge clk_sys);
        end
        repeat (40) @(posedge clk_sys);
        rdcnt(1'b0, fin);
    endtask
    task automatic tally_and_finish();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (30000) @(posedge clk_sys);
        n_errors++;
        $display("ERROR t=%0t timeout got %h exp %h", $time, 1, 0);
        tally_and_finish();
    end
    initial
    begin
        seed = 32'hE6CB;
        req = '0;
        rst_n = 1'b0;
        low_osc = 1'b0;
        high_osc = 1'b0;
        ev_go = 1'b0;
        ev_hold = 8'h28;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        cmp({4'h0, sclk, pulse, irq1, irq0}, 8'h04);
        for (i = 0; i < 12; i++) chk(`IDX_TIMER_MODE_CONFIG + 16'(i), 4'h0);
        chk(`IDX_TIMER_INTERRUPT_ENABLE, 4'h0);
        chk(`IDX_TIMER_INTERRUPT_FLAGS, 4'h0);
        wr(16'hFFD0, 4'hF);
        chk(16'hFFD0, 4'h0);
        r0 = 8'($random(seed)) | 8'h01;
        r1 = 8'($random(seed));
        setrl(1'b1, r1);
        setrl(1'b0, 8'h10);
        wr(`IDX_TIMER_ZERO_CONTROL, 4'h1);
        chk(`IDX_TIMER_ZERO_COUNT_LOW, 4'h0);
        tick(1'b0, 1);
        chk(`IDX_TIMER_ZERO_COUNT_HIGH, 4'h1);
        rdcnt(1'b0, 8'h0F);
        for (i = 0; i < 4; i++)
        begin
            wr(`IDX_CLOCK_SOURCE_AND_OUTPUT_CTRL, {3'h0, i[0]});
            setrl(1'b0, r0);
            wr(`IDX_TIMER_ZERO_CONTROL, {i[1:0], 2'b01});
            chk(`IDX_TIMER_ZERO_CONTROL, {i[1:0], 2'b01});
            tick(!i[0], 3);
            tick(i[0], div_of(i[1:0]) - 1);
            rdcnt(1'b0, r0);
            tick(i[0], 1);
            rdcnt(1'b0, r0 - 8'h1);
            wr(`IDX_TIMER_ZERO_CONTROL, {i[1:0], 2'b00});
            tick(i[0], 4);
            rdcnt(1'b0, r0 - 8'h1);
        end
        wr(`IDX_CLOCK_SOURCE_AND_OUTPUT_CTRL, 4'h4);
        setrl(1'b0, 8'h02);
        wr(`IDX_TIMER_ZERO_CONTROL, 4'h1);
        tick(1'b0, 2);
        chk(`IDX_TIMER_INTERRUPT_FLAGS, 4'h0);
        pb = pt;
        tick(1'b0, 1);
        rdcnt(1'b0, 8'h02);
        chk(`IDX_TIMER_INTERRUPT_FLAGS, 4'h1);
        cmp(8'(pt - pb), 8'h01);
        cmp({7'h0, irq0}, 8'h00);
        wr(`IDX_TIMER_INTERRUPT_ENABLE, 4'h1);
        repeat (2) @(posedge clk_sys);
        cmp({7'h0, irq0}, 8'h01);
        wr(`IDX_TIMER_INTERRUPT_FLAGS, 4'h0);
        chk(`IDX_TIMER_INTERRUPT_FLAGS, 4'h1);
        wr(`IDX_TIMER_INTERRUPT_FLAGS, 4'h1);
        chk(`IDX_TIMER_INTERRUPT_FLAGS, 4'h0);
        wr(`IDX_TIMER_MODE_CONFIG, 4'h4);
        wr(`IDX_CLOCK_SOURCE_AND_OUTPUT_CTRL, 4'h1);
        setrl(1'b0, 8'h08);
        wr(`IDX_TIMER_ZERO_CONTROL, 4'hD);
        tick(1'b1, 2);
        tick(1'b0, 2);
        ev(8'h28, 8'h07, 8'h07);
        wr(`IDX_TIMER_MODE_CONFIG, 4'h5);
        ev(8'h28, 8'h07, 8'h06);
        wr(`IDX_TIMER_MODE_CONFIG, 4'h7);
        ev(8'h03, 8'h06, 8'h06);
        ev(8'h28, 8'h06, 8'h05);
        wr(`IDX_TIMER_ZERO_CONTROL, 4'h0);
        wr(`IDX_TIMER_MODE_CONFIG, 4'h8);
        wr(`IDX_CLOCK_SOURCE_AND_OUTPUT_CTRL, 4'h0);
        wr(`IDX_TIMER_INTERRUPT_FLAGS, 4'h3);
        setrl(1'b1, 8'h01);
        setrl(1'b0, 8'h01);
        wr(`IDX_TIMER_ZERO_CONTROL, 4'h1);
        base = sclk_edges;
        tick(1'b0, 4);
        cmp(sclk_edges - 8'(base), 8'h01);
        cmp({7'h0, pulse}, 8'h01);
        chk(`IDX_TIMER_INTERRUPT_FLAGS, 4'h2);
        cmp({7'h0, irq1}, 8'h00);
        wr(`IDX_CLOCK_SOURCE_AND_OUTPUT_CTRL, 4'h4);
        // Let the change count of the enable step settle first
        @(posedge clk_sys);
        pb = pt;
        tick(1'b0, 8);
        cmp(8'(pt - pb), 8'h02);
        cmp(sclk_edges - 8'(base), 8'h03);
        rdcnt(1'b1, 8'h01);
        tally_and_finish();
    end
endmodule
`default_nettype wire
